// File: core/branch_likely_special_exec.sv
// execute logic for the likely branches, memory ordering, system call and breakpoint
// assumes the pipeline presents one instruction per instr_valid pulse, the delay
// slot being the next instr_valid after a branch, and that all inputs are synchronous
`timescale 1ns/10ps

module branch_likely_special_exec import branch_likely_pkg::*; #(
  parameter logic [WORD_W-1:0] EXC_VECTOR = EXC_VECTOR_DEFAULT
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic instr_valid,
  input wire logic [WORD_W-1:0] instr,
  input wire logic [WORD_W-1:0] instr_pc,
  input wire logic [WORD_W-1:0] source_register_value,
  input wire logic system_control_coprocessor_cond,
  input wire logic mem_ops_pending,
  output logic redirect_valid,
  output logic [WORD_W-1:0] redirect_target,
  output logic slot_cancel,
  output logic slot_commit,
  output logic link_write_en,
  output logic [4:0] link_write_index,
  output logic [WORD_W-1:0] link_write_data,
  output logic exc_valid,
  output logic [4:0] exc_code,
  output logic mem_order_hold
);

  decode_if dec ();

  instr_decoder u_decoder (
    .instr_valid(instr_valid),
    .instr(instr),
    .dec(dec.producer)
  );

  // carry dropped on purpose: addresses wrap
  function automatic logic [WORD_W-1:0] add_word(input logic [WORD_W-1:0] a,
      input logic [WORD_W-1:0] b);
    logic [WORD_W:0] sum;
    sum = {1'b0, a} + {1'b0, b};
    return sum[WORD_W-1:0];
  endfunction : add_word

  // offset shifted left then sign-extended to a full word
  function automatic logic [WORD_W-1:0] scaled_offset(input logic [OFFSET_W-1:0] off);
    logic [OFFSET_W+OFFSET_SHIFT-1:0] shifted;
    shifted = {off, {OFFSET_SHIFT{1'b0}}};
    return {{(WORD_W-OFFSET_W-OFFSET_SHIFT){shifted[OFFSET_W+OFFSET_SHIFT-1]}}, shifted};
  endfunction : scaled_offset

  // decode side is purely combinational; everything below is registered once
  logic is_branch;
  logic cond_true;
  logic [WORD_W-1:0] slot_pc;
  logic [WORD_W-1:0] branch_target;
  logic accept_branch;
  logic in_slot;
  logic slot_special_ok;

  assign is_branch = (dec.branch_kind != BR_NONE);
  assign slot_pc = add_word(instr_pc, SLOT_DISTANCE);
  assign branch_target = add_word(slot_pc, scaled_offset(dec.offset));

  // condition taken with the branch; later changes of the inputs are ignored
  always_comb begin
    case (dec.branch_kind)
      BR_NEG: cond_true = source_register_value[WORD_W-1];
      BR_NONNEG: cond_true = ~source_register_value[WORD_W-1];
      BR_COP_TRUE: cond_true = system_control_coprocessor_cond;
      BR_COP_FALSE: cond_true = ~system_control_coprocessor_cond;
      default: cond_true = 1'b0;
    endcase
  end

  // slot tracking: taken decision and target held until the delay slot shows up
  // no timeout: the pipeline must always present the slot
  slot_state_t slot_state_reg, slot_state_next;
  logic taken_reg, taken_next;
  logic [WORD_W-1:0] target_reg, target_next;
  logic slot_cancel_reg, slot_cancel_next;
  logic slot_commit_reg, slot_commit_next;
  logic branch_redirect;

  // a branch in a delay slot is decoded but not accepted; its behaviour is undefined anyway
  assign in_slot = (slot_state_reg == SLOT_WAIT);
  assign accept_branch = dec.valid && is_branch && !in_slot;
  // specials in a slot only run when the slot itself survives
  assign slot_special_ok = !in_slot || taken_reg;

  always_comb begin
    slot_state_next = slot_state_reg;
    taken_next = taken_reg;
    target_next = target_reg;
    slot_cancel_next = 1'b0;
    slot_commit_next = 1'b0;
    branch_redirect = 1'b0;
    case (slot_state_reg)
      SLOT_IDLE: begin
        if (accept_branch) begin
          slot_state_next = SLOT_WAIT;
          taken_next = cond_true;
          target_next = branch_target;
        end
      end
      SLOT_WAIT: begin
        // whatever comes next is the slot, a branch included
        if (dec.valid) begin
          slot_state_next = SLOT_IDLE;
          if (taken_reg) begin
            slot_commit_next = 1'b1;
            branch_redirect = 1'b1;
          end else begin
            slot_cancel_next = 1'b1;
          end
        end
      end
      default: slot_state_next = SLOT_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      slot_state_reg <= SLOT_IDLE;
      taken_reg <= 1'b0;
      target_reg <= '0;
      slot_cancel_reg <= 1'b0;
      slot_commit_reg <= 1'b0;
    end else begin
      slot_state_reg <= slot_state_next;
      taken_reg <= taken_next;
      target_reg <= target_next;
      slot_cancel_reg <= slot_cancel_next;
      slot_commit_reg <= slot_commit_next;
    end
  end

  // link write, issued with the branch regardless of the outcome
  // data from the branch pc, so a cancelled slot cannot disturb it
  logic link_we_reg, link_we_next;
  logic [WORD_W-1:0] link_data_reg, link_data_next;
  logic [4:0] link_index_reg, link_index_next;

  always_comb begin
    link_we_next = 1'b0;
    link_data_next = link_data_reg;
    link_index_next = link_index_reg;
    if (accept_branch && dec.link) begin
      link_we_next = 1'b1;
      link_data_next = add_word(instr_pc, LINK_DISTANCE);
      link_index_next = LINK_REG_INDEX;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      link_we_reg <= 1'b0;
      link_data_reg <= '0;
      link_index_reg <= '0;
    end else begin
      link_we_reg <= link_we_next;
      link_data_reg <= link_data_next;
      link_index_reg <= link_index_next;
    end
  end

  // exceptions and the single redirect port; an exception outranks a branch redirect
  // a trapping slot of a taken branch still commits; only the target changes
  logic exc_valid_reg, exc_valid_next;
  logic [4:0] exc_code_reg, exc_code_next;
  logic redirect_valid_reg, redirect_valid_next;
  logic [WORD_W-1:0] redirect_target_reg, redirect_target_next;
  logic take_special;

  assign take_special = dec.valid && slot_special_ok;

  always_comb begin
    exc_valid_next = 1'b0;
    exc_code_next = exc_code_reg;
    redirect_valid_next = 1'b0;
    redirect_target_next = redirect_target_reg;
    if (branch_redirect) begin
      redirect_valid_next = 1'b1;
      redirect_target_next = target_reg;
    end
    if (take_special) begin
      case (dec.special_kind)
        SPC_SYSCALL: begin
          exc_valid_next = 1'b1;
          exc_code_next = EXC_CODE_SYSCALL;
          redirect_valid_next = 1'b1;
          redirect_target_next = EXC_VECTOR;
        end
        SPC_BREAK: begin
          exc_valid_next = 1'b1;
          exc_code_next = EXC_CODE_BREAK;
          redirect_valid_next = 1'b1;
          redirect_target_next = EXC_VECTOR;
        end
        default: exc_valid_next = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      exc_valid_reg <= 1'b0;
      exc_code_reg <= '0;
      redirect_valid_reg <= 1'b0;
      redirect_target_reg <= '0;
    end else begin
      exc_valid_reg <= exc_valid_next;
      exc_code_reg <= exc_code_next;
      redirect_valid_reg <= redirect_valid_next;
      redirect_target_reg <= redirect_target_next;
    end
  end

  // memory ordering: hold at least one cycle, then until the pipeline is empty
  // no counter of its own: the pending flag is the only drain measure
  order_state_t order_state_reg, order_state_next;
  logic hold_reg, hold_next;
  logic sync_seen;

  // a sync in a cancelled slot is dropped with it
  assign sync_seen = take_special && (dec.special_kind == SPC_SYNC);

  always_comb begin
    order_state_next = order_state_reg;
    hold_next = hold_reg;
    case (order_state_reg)
      ORDER_IDLE: begin
        if (sync_seen) begin
          order_state_next = ORDER_DRAIN;
          hold_next = 1'b1;
        end
      end
      ORDER_DRAIN: begin
        if (!mem_ops_pending && !sync_seen) begin
          order_state_next = ORDER_IDLE;
          hold_next = 1'b0;
        end
        // a fresh sync holds one more cycle
        if (sync_seen) begin
          hold_next = 1'b1;
        end
      end
      default: begin
        order_state_next = ORDER_IDLE;
        hold_next = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      order_state_reg <= ORDER_IDLE;
      hold_reg <= 1'b0;
    end else begin
      order_state_reg <= order_state_next;
      hold_reg <= hold_next;
    end
  end

  // every output straight from a register
  assign redirect_valid = redirect_valid_reg;
  assign redirect_target = redirect_target_reg;
  assign slot_cancel = slot_cancel_reg;
  assign slot_commit = slot_commit_reg;
  assign link_write_en = link_we_reg;
  assign link_write_index = link_index_reg;
  assign link_write_data = link_data_reg;
  assign exc_valid = exc_valid_reg;
  assign exc_code = exc_code_reg;
  assign mem_order_hold = hold_reg;

endmodule : branch_likely_special_exec

// File: core/branch_likely_pkg.sv
// constants, encodings and types for the likely-branch and special-instruction unit
// assumes 32-bit instruction words and a 32-bit program counter
package branch_likely_pkg;

  localparam int WORD_W = 32;
  localparam int OFFSET_W = 16;

  // instruction field positions
  localparam int OPC_MSB = 31;
  localparam int OPC_LSB = 26;
  localparam int SRC_MSB = 25;
  localparam int SRC_LSB = 21;
  localparam int SUB_MSB = 20;
  localparam int SUB_LSB = 16;
  localparam int FUNC_MSB = 5;
  localparam int FUNC_LSB = 0;
  localparam int OFF_MSB = 15;
  localparam int OFF_LSB = 0;

  // primary opcodes
  localparam logic [5:0] OPC_SPECIAL = 6'h00;
  localparam logic [5:0] OPC_REGISTER_IMMEDIATE_CLASS = 6'h01;
  localparam logic [5:0] OPC_SYSTEM_CONTROL_COP = 6'h10;

  // sub codes of the register-immediate class
  localparam logic [4:0] SUB_NEG_LIKELY = 5'h02;
  localparam logic [4:0] SUB_NONNEG_LIKELY = 5'h03;
  localparam logic [4:0] SUB_NEG_LINK_LIKELY = 5'h12;
  localparam logic [4:0] SUB_NONNEG_LINK_LIKELY = 5'h13;

  // coprocessor branch: selector in source field, condition in sub field
  localparam logic [4:0] COP_BRANCH_SEL = 5'h08;
  localparam logic [4:0] COP_FALSE_LIKELY = 5'h02;
  localparam logic [4:0] COP_TRUE_LIKELY = 5'h03;

  // function codes of the register-type format
  localparam logic [5:0] FUNC_SYSCALL = 6'h0C;
  localparam logic [5:0] FUNC_BREAK = 6'h0D;
  localparam logic [5:0] FUNC_SYNC = 6'h0F;

  localparam logic [4:0] LINK_REG_INDEX = 5'h1F;
  localparam logic [WORD_W-1:0] SLOT_DISTANCE = 32'h0000_0004;
  localparam logic [WORD_W-1:0] LINK_DISTANCE = 32'h0000_0008;
  localparam int OFFSET_SHIFT = 2;

  localparam logic [4:0] EXC_CODE_SYSCALL = 5'h08;
  localparam logic [4:0] EXC_CODE_BREAK = 5'h09;
  localparam logic [WORD_W-1:0] EXC_VECTOR_DEFAULT = 32'h0000_0180;

  typedef enum logic [2:0] {BR_NONE, BR_NEG, BR_NONNEG, BR_COP_TRUE, BR_COP_FALSE} branch_kind_t;
  typedef enum logic [1:0] {SPC_NONE, SPC_SYNC, SPC_SYSCALL, SPC_BREAK} special_kind_t;
  typedef enum logic {SLOT_IDLE, SLOT_WAIT} slot_state_t;
  typedef enum logic {ORDER_IDLE, ORDER_DRAIN} order_state_t;

endpackage : branch_likely_pkg

// File: core/decode_if.sv
// decoded instruction fields passed from the decoder to the execute logic
// assumes the producer is purely combinational on the current instruction
`timescale 1ns/10ps
interface decode_if;
  import branch_likely_pkg::*;
  logic valid;
  branch_kind_t branch_kind;
  logic link;
  special_kind_t special_kind;
  logic [OFFSET_W-1:0] offset;

  modport producer (output valid, output branch_kind, output link, output special_kind,
    output offset);
  modport consumer (input valid, input branch_kind, input link, input special_kind,
    input offset);
endinterface : decode_if

// File: core/instr_decoder.sv
// combinational decoder for the likely branches and the special instructions
// assumes the instruction word is stable while instr_valid is high
`timescale 1ns/10ps
module instr_decoder import branch_likely_pkg::*; (
  input wire logic instr_valid,
  input wire logic [WORD_W-1:0] instr,
  decode_if.producer dec
);

  logic [5:0] opc;
  logic [4:0] src_field;
  logic [4:0] sub_field;
  logic [5:0] func_field;

  assign opc = instr[OPC_MSB:OPC_LSB];
  assign src_field = instr[SRC_MSB:SRC_LSB];
  assign sub_field = instr[SUB_MSB:SUB_LSB];
  assign func_field = instr[FUNC_MSB:FUNC_LSB];

  always_comb begin
    dec.valid = instr_valid;
    dec.branch_kind = BR_NONE;
    dec.link = 1'b0;
    dec.special_kind = SPC_NONE;
    dec.offset = instr[OFF_MSB:OFF_LSB];
    case (opc)
      OPC_REGISTER_IMMEDIATE_CLASS: begin
        case (sub_field)
          SUB_NEG_LIKELY: dec.branch_kind = BR_NEG;
          SUB_NONNEG_LIKELY: dec.branch_kind = BR_NONNEG;
          SUB_NEG_LINK_LIKELY: begin
            dec.branch_kind = BR_NEG;
            dec.link = 1'b1;
          end
          SUB_NONNEG_LINK_LIKELY: begin
            dec.branch_kind = BR_NONNEG;
            dec.link = 1'b1;
          end
          default: dec.branch_kind = BR_NONE;
        endcase
      end
      OPC_SYSTEM_CONTROL_COP: begin
        if (src_field == COP_BRANCH_SEL) begin
          case (sub_field)
            COP_TRUE_LIKELY: dec.branch_kind = BR_COP_TRUE;
            COP_FALSE_LIKELY: dec.branch_kind = BR_COP_FALSE;
            default: dec.branch_kind = BR_NONE;
          endcase
        end
      end
      OPC_SPECIAL: begin
        case (func_field)
          FUNC_SYNC: dec.special_kind = SPC_SYNC;
          FUNC_SYSCALL: dec.special_kind = SPC_SYSCALL;
          FUNC_BREAK: dec.special_kind = SPC_BREAK;
          default: dec.special_kind = SPC_NONE;
        endcase
      end
      default: dec.branch_kind = BR_NONE;
    endcase
  end

endmodule : instr_decoder

// File: tb/branch_likely_special_exec_assertions.sv
// checker for the likely-branch and special-instruction unit
// assumes it is bound to the unit and sees only its ports
`timescale 1ns/10ps
module branch_likely_special_exec_assertions import branch_likely_pkg::*; #(
  parameter logic [WORD_W-1:0] EXC_VECTOR = EXC_VECTOR_DEFAULT
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic instr_valid,
  input wire logic [WORD_W-1:0] instr,
  input wire logic [WORD_W-1:0] instr_pc,
  input wire logic mem_ops_pending,
  input wire logic redirect_valid,
  input wire logic [WORD_W-1:0] redirect_target,
  input wire logic slot_cancel,
  input wire logic slot_commit,
  input wire logic link_write_en,
  input wire logic [4:0] link_write_index,
  input wire logic [WORD_W-1:0] link_write_data,
  input wire logic exc_valid,
  input wire logic [4:0] exc_code,
  input wire logic mem_order_hold
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  property p_link;
    link_write_en |-> link_write_index == LINK_REG_INDEX
      && link_write_data == $past(instr_pc) + LINK_DISTANCE; endproperty
  a_link: assert property (p_link) else $error("link write wrong");
  property p_link_once;
    link_write_en |=> !link_write_en; endproperty
  a_link_once: assert property (p_link_once) else $error("link in slot");
  property p_cancel;
    slot_cancel |-> !redirect_valid && !exc_valid && !slot_commit; endproperty
  a_cancel: assert property (p_cancel) else $error("cancelled slot acted");
  property p_commit;
    slot_commit |-> redirect_valid && $past(instr_valid); endproperty
  a_commit: assert property (p_commit) else $error("commit without redirect");
  property p_exc_vec;
    exc_valid |-> redirect_valid && redirect_target == EXC_VECTOR; endproperty
  a_exc_vec: assert property (p_exc_vec) else $error("exception vector wrong");
  property p_exc_code;
    exc_valid |-> $past(instr_valid) && exc_code == ($past(instr[FUNC_MSB:FUNC_LSB])
      == FUNC_SYSCALL ? EXC_CODE_SYSCALL : EXC_CODE_BREAK); endproperty
  a_exc_code: assert property (p_exc_code) else $error("exception code wrong");
  property p_hold_keep;
    mem_order_hold && mem_ops_pending |=> mem_order_hold; endproperty
  a_hold_keep: assert property (p_hold_keep) else $error("hold dropped early");
  property p_hold_end;
    mem_order_hold && !mem_ops_pending && !instr_valid |=> !mem_order_hold; endproperty
  a_hold_end: assert property (p_hold_end) else $error("hold stuck");
  property p_hold_src;
    $rose(mem_order_hold) |-> $past(instr_valid)
      && $past(instr[FUNC_MSB:FUNC_LSB]) == FUNC_SYNC; endproperty
  a_hold_src: assert property (p_hold_src) else $error("hold without sync");
endmodule : branch_likely_special_exec_assertions

// File: tb/mem_pipe_model.sv
// memory pipeline stand-in: one load/store of len cycles at a time
// assumes start is a one-cycle request from the bench
`timescale 1ns/10ps
module mem_pipe_model (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic start,
  input wire logic hold,
  input wire logic [3:0] len,
  output logic pending
);
  logic [3:0] count_reg;
  always_ff @(posedge clk) begin
    if (!reset_n) count_reg <= 4'h0;
    else if (start && !hold && count_reg == 4'h0) count_reg <= len;
    else if (count_reg != 4'h0) count_reg <= count_reg - 4'h1;
  end
  assign pending = count_reg != 4'h0;
endmodule : mem_pipe_model

// File: tb/tb_branch_likely_special_exec.sv
// self-checking bench for the likely-branch and special-instruction unit
// assumes the memory model and checker are compiled before it
`timescale 1ns/10ps
module tb_branch_likely_special_exec import branch_likely_pkg::*;;
  logic clk, reset_n, instr_valid, cond, mem_ops_pending, mem_start;
  logic redirect_valid, slot_cancel, slot_commit, link_write_en, exc_valid, mem_order_hold;
  logic [WORD_W-1:0] instr, instr_pc, src_val, redirect_target, link_write_data;
  logic [4:0] link_write_index, exc_code;
  logic [3:0] mem_len;
  int fails, total_checks, cycles;

  branch_likely_special_exec u_dut (.clk(clk), .reset_n(reset_n),
    .instr_valid(instr_valid), .instr(instr), .instr_pc(instr_pc),
    .source_register_value(src_val), .system_control_coprocessor_cond(cond),
    .mem_ops_pending(mem_ops_pending), .redirect_valid(redirect_valid),
    .redirect_target(redirect_target), .slot_cancel(slot_cancel),
    .slot_commit(slot_commit), .link_write_en(link_write_en),
    .link_write_index(link_write_index), .link_write_data(link_write_data),
    .exc_valid(exc_valid), .exc_code(exc_code), .mem_order_hold(mem_order_hold));
  mem_pipe_model u_mem (.clk(clk), .reset_n(reset_n), .start(mem_start),
    .hold(mem_order_hold), .len(mem_len), .pending(mem_ops_pending));

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // one instruction; returns just after the edge that answers it
  task automatic put(input logic [31:0] w, input logic [31:0] pc, input logic [31:0] v,
    input logic c);
    @(posedge clk);
    instr_valid <= 1'h1;
    instr <= w;
    instr_pc <= pc;
    src_val <= v;
    cond <= c;
    @(posedge clk);
    instr_valid <= 1'h0;
    #1;
  endtask : put

  task automatic pair(input logic [31:0] w, input logic [31:0] v, input logic c,
    input logic taken, input logic lnk, input logic [31:0] slot);
    logic [31:0] pc;
    logic [31:0] tgt;
    logic sc;
    pc = 32'h0001_0000;
    tgt = pc + SLOT_DISTANCE + {{14{w[15]}}, w[15:0], 2'h0};
    sc = slot[31:26] == OPC_SPECIAL && slot[5:0] == FUNC_SYSCALL;
    put(w, pc, v, c);
    chk(link_write_en, lnk);
    if (lnk) chk(link_write_data, pc + LINK_DISTANCE);
    if (lnk) chk(link_write_index, LINK_REG_INDEX);
    chk(redirect_valid, 1'h0);
    // slot value would take a link branch if it were wrongly accepted
    put(slot, pc + SLOT_DISTANCE, 32'hFFFF_FFFF, c);
    chk(link_write_en, 1'h0);
    chk(slot_cancel, !taken);
    chk(slot_commit, taken);
    chk(redirect_valid, taken);
    chk(exc_valid, taken && sc);
    if (taken) chk(redirect_target, sc ? EXC_VECTOR_DEFAULT : tgt);
  endtask : pair

  task automatic t_zero;
    logic [4:0] subs [4];
    logic [31:0] vals [4];
    logic [31:0] w;
    subs = '{SUB_NEG_LIKELY, SUB_NONNEG_LIKELY, SUB_NEG_LINK_LIKELY, SUB_NONNEG_LINK_LIKELY};
    vals = '{32'h8000_0000, 32'h0000_0000, 32'h7FFF_FFFF, 32'hFFFF_FFFF};
    for (int s = 0; s < 4; s++) begin
      for (int k = 0; k < 4; k++) begin
        w = {OPC_REGISTER_IMMEDIATE_CLASS, 5'h03, subs[s], k[0] ? 16'hFFF0 : 16'h0024};
        pair(w, vals[k], 1'h0, subs[s][0] ^ vals[k][31], subs[s][4],
          {OPC_REGISTER_IMMEDIATE_CLASS, 5'h00, SUB_NEG_LINK_LIKELY, 16'h0000});
      end
    end
  endtask : t_zero

  task automatic t_cop;
    logic [31:0] w;
    for (int k = 0; k < 4; k++) begin
      w = {OPC_SYSTEM_CONTROL_COP, COP_BRANCH_SEL,
        k[1] ? COP_TRUE_LIKELY : COP_FALSE_LIKELY, 16'h8001};
      pair(w, 32'h0000_0000, k[0], k[1] == k[0], 1'h0,
        k[0] ? {OPC_SPECIAL, 20'h0, FUNC_SYSCALL} : 32'h0000_0000);
    end
  endtask : t_cop

  task automatic t_exc;
    for (int k = 0; k < 2; k++) begin
      put({OPC_SPECIAL, 20'h0, k ? FUNC_BREAK : FUNC_SYSCALL}, 32'h0000_2000, 32'h0, 1'h0);
      chk(exc_valid, 1'h1);
      chk(redirect_valid, 1'h1);
      chk(exc_code, k ? EXC_CODE_BREAK : EXC_CODE_SYSCALL);
      chk(redirect_target, EXC_VECTOR_DEFAULT);
    end
    // function code outside the register-type format
    put({OPC_SYSTEM_CONTROL_COP, 20'h0, FUNC_SYSCALL}, 32'h0000_2000, 32'h0, 1'h0);
    chk(exc_valid, 1'h0);
  endtask : t_exc

  task automatic t_sync;
    int n;
    @(posedge clk);
    mem_start <= 1'h1;
    mem_len <= 4'h4;
    @(posedge clk);
    mem_start <= 1'h0;
    put({OPC_SPECIAL, 20'h0, FUNC_SYNC}, 32'h0000_3000, 32'h0, 1'h0);
    chk(mem_order_hold, 1'h1);
    for (n = 0; n < 8 && mem_order_hold; n++) begin
      @(posedge clk);
      #1;
    end
    // partner busy two more edges, falls on the third
    chk(n, 3);
    put({OPC_SPECIAL, 20'h0, FUNC_SYNC}, 32'h0000_3004, 32'h0, 1'h0);
    chk(mem_order_hold, 1'h1);
    @(posedge clk);
    #1;
    chk(mem_order_hold, 1'h0);
  endtask : t_sync

  initial begin
    clk = 1'h0;
    forever #2.5 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      fails++;
      tally_and_finish();
    end
  end

  initial begin
    reset_n = 1'h0;
    instr_valid = 1'h0;
    instr = 32'h0;
    instr_pc = 32'h0;
    src_val = 32'h0;
    cond = 1'h0;
    mem_start = 1'h0;
    mem_len = 4'h0;
    repeat (10) @(posedge clk);
    reset_n <= 1'h1;
    t_zero();
    t_cop();
    t_exc();
    t_sync();
    tally_and_finish();
  end
endmodule : tb_branch_likely_special_exec

bind branch_likely_special_exec branch_likely_special_exec_assertions #(
  .EXC_VECTOR(EXC_VECTOR)) u_chk (.clk(clk), .reset_n(reset_n),
  .instr_valid(instr_valid), .instr(instr), .instr_pc(instr_pc),
  .mem_ops_pending(mem_ops_pending), .redirect_valid(redirect_valid),
  .redirect_target(redirect_target), .slot_cancel(slot_cancel), .slot_commit(slot_commit),
  .link_write_en(link_write_en), .link_write_index(link_write_index),
  .link_write_data(link_write_data), .exc_valid(exc_valid), .exc_code(exc_code),
  .mem_order_hold(mem_order_hold));
